/* exec_defines.svh */
// Constants for the instruction execution block: opcodes, bus offsets,
// status bit positions and reset values.
// Assumes inclusion by bare name from the package and the core.
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and memory depth
// ----------------------------------------------------------------
`define INSTR_W         14
`define PC_W            13
`define DATA_W          8
`define MEM_DEPTH       128
`define ADDR_W          8
`define WDT_W           8

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define OP_AND_LIT      6'h39
`define OP_AND_REG      6'h05
`define OP_COMP_REG     6'h09
`define OP_BIT_GROUP    2'h1
`define OP_SKIP_CLR     2'h2
`define OP_SKIP_SET     2'h3
`define OP_CALL         3'h4
`define INSTR_WDT_CLR   14'h0064
`define PORT_INDEX      7'h05

// ----------------------------------------------------------------
// Bus offsets (0x00..0x7f reach the register file)
// ----------------------------------------------------------------
`define ADDR_ACCUM      8'h80
`define ADDR_STATUS     8'h81
`define ADDR_UPPER_PC   8'h82
`define ADDR_PC_LO      8'h83
`define ADDR_PC_HI      8'h84
`define ADDR_WDT_COUNT  8'h85
`define ADDR_WDT_PRE    8'h86
`define ADDR_CONTROL    8'h87
`define ADDR_STACK      8'h88

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define STAT_ZERO       2
`define STAT_PD         3
`define STAT_TO         4
`define CTRL_WDT_EN     0
`define RST_PC          13'h0000
`define RST_DATA        8'h00

`endif

/* exec_pkg.sv */
// Types shared by the instruction execution block and its testbench.
// Assumes exec_defines.svh sits in the include path.
`default_nettype none

`include "exec_defines.svh"

package exec_pkg;

    // Two phases: normal execution, or the forced no-operation cycle
    typedef enum logic {
        ST_EXEC,
        ST_SECOND
    } exec_state_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic               wr;
        logic               rd;
    } reg_bus_req_t;

    typedef struct packed {
        logic               valid;
        logic [`INSTR_W-1:0] word;
    } instr_in_t;

    typedef struct packed {
        exec_state_t                          state;
        logic                                 second_advance;
        logic                                 nop_cycle;
        logic [`PC_W-1:0]                     pc;
        logic [`DATA_W-1:0]                   accumulator;
        logic                                 zero;
        logic                                 power_down_flag;
        logic                                 watchdog_expiry_flag;
        logic [4:0]                           upper_pc_latch;
        logic [`MEM_DEPTH-1:0][`DATA_W-1:0]   mem;
        logic [`WDT_W-1:0]                    watchdog_counter;
        logic [`WDT_W-1:0]                    wdt_prescaler;
        logic                                 wdt_enable;
        logic                                 wdt_timeout;
        logic [`DATA_W-1:0]                   bus_rdata;
    } core_state_t;

endpackage

`default_nettype wire

/* return_stack.sv */
// Hardware return stack: circular, overwrites the oldest entry when full.
// Assumes push is qualified by the caller; state freezes with clk_en low.
`default_nettype none

`include "exec_defines.svh"

module return_stack #(
    parameter int DEPTH = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              push,
    input  wire logic [`PC_W-1:0]  push_addr,
    output logic      [`PC_W-1:0]  stack_top,
    output logic      [7:0]        depth
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][`PC_W-1:0] slot;
        logic [PW-1:0]               ptr;
        logic [`PC_W-1:0]            top;
        logic [7:0]                  depth;
    } stack_state_t;

    stack_state_t s;
    stack_state_t next_s;

    // ----------------------------------------------------------------
    // Push; depth saturates since old entries are overwritten
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.slot[s.ptr] = push_addr;
            next_s.ptr         = PW'(s.ptr + 1'b1);
            next_s.top         = push_addr;
            if (s.depth < 8'(DEPTH)) begin
                next_s.depth = 8'(s.depth + 8'h01);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign stack_top = s.top;
    assign depth     = s.depth;

endmodule

`default_nettype wire

/* logic_skip_call_instr_exec.sv */
// Executes literal/register AND, complement, bit test with skip,
// watchdog clear and subroutine call on an 8-bit core model.
// Assumes instructions arrive synchronous to clk_sys, one per cycle,
// for the address shown on pc; register bus is a plain strobe port.
`default_nettype none

`include "exec_defines.svh"

module logic_skip_call_instr_exec #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire exec_pkg::instr_in_t   instr_in,
    input  wire logic [`DATA_W-1:0]    port_pins,
    input  wire exec_pkg::reg_bus_req_t bus_req,
    output logic      [`DATA_W-1:0]    bus_rdata,
    output logic      [`PC_W-1:0]      pc,
    output logic                       nop_cycle,
    output logic      [`DATA_W-1:0]    port_latch,
    output logic      [`PC_W-1:0]      stack_top,
    output logic                       watchdog_timeout
);
    import exec_pkg::*;

    localparam core_state_t RESET_STATE = '{
        state:                ST_EXEC,
        power_down_flag:      1'b1,
        watchdog_expiry_flag: 1'b1,
        default:              '0
    };

    core_state_t        s;
    core_state_t        next_s;
    logic               push;
    logic [`PC_W-1:0]   pc_plus_one;
    logic [7:0]         stack_depth;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Port register reads the pins, so a pulled-down input is seen low
    function automatic logic [`DATA_W-1:0] operand_of(
        input logic [`MEM_DEPTH-1:0][`DATA_W-1:0] mem,
        input logic [6:0]                         idx,
        input logic [`DATA_W-1:0]                 pins
    );
        logic [`DATA_W-1:0] v;
        v = (idx == `PORT_INDEX) ? pins : mem[idx];
        return v;
    endfunction

    function automatic logic is_zero(input logic [`DATA_W-1:0] v);
        return (v == `RST_DATA);
    endfunction

    function automatic logic [`DATA_W-1:0] status_of(input core_state_t c);
        logic [`DATA_W-1:0] v;
        v              = '0;
        v[`STAT_ZERO]  = c.zero;
        v[`STAT_PD]    = c.power_down_flag;
        v[`STAT_TO]    = c.watchdog_expiry_flag;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Decode of the presented word
    // ----------------------------------------------------------------
    logic [`INSTR_W-1:0] w;
    logic                fire;
    logic                dec_and_lit;
    logic                dec_and_reg;
    logic                dec_comp;
    logic                dec_skip_clr;
    logic                dec_skip_set;
    logic                dec_wdt_clr;
    logic                dec_call;
    logic [`DATA_W-1:0]  opnd;
    logic                tested_bit;

    // Bit tests: group bits, then sense, bit number and register
    assign w            = instr_in.word;
    assign fire         = clk_en && (s.state == ST_EXEC) && instr_in.valid;
    assign dec_and_lit  = (w[13:8] == `OP_AND_LIT);
    assign dec_and_reg  = (w[13:8] == `OP_AND_REG);
    assign dec_comp     = (w[13:8] == `OP_COMP_REG);
    assign dec_skip_clr = (w[13:12] == `OP_BIT_GROUP)
                        && (w[11:10] == `OP_SKIP_CLR);
    assign dec_skip_set = (w[13:12] == `OP_BIT_GROUP)
                        && (w[11:10] == `OP_SKIP_SET);
    assign dec_wdt_clr  = (w == `INSTR_WDT_CLR);
    assign dec_call     = (w[13:11] == `OP_CALL);
    assign opnd         = operand_of(s.mem, w[6:0], port_pins);
    assign tested_bit   = opnd[w[9:7]];
    assign pc_plus_one  = `PC_W'(s.pc + 1'b1);

    // ----------------------------------------------------------------
    // Next-state logic: watchdog, bus, then instruction (last wins)
    // ----------------------------------------------------------------
    always_comb begin
        logic [`DATA_W-1:0] res;
        res                = '0;
        next_s             = s;
        next_s.bus_rdata   = '0;
        next_s.wdt_timeout = 1'b0;
        push               = 1'b0;

        // Watchdog runs only when software enables it
        if (s.wdt_enable) begin
            next_s.wdt_prescaler = `WDT_W'(s.wdt_prescaler + 1'b1);
            if (&s.wdt_prescaler) begin
                next_s.watchdog_counter =
                    `WDT_W'(s.watchdog_counter + 1'b1);
                if (&s.watchdog_counter) begin
                    next_s.watchdog_expiry_flag = 1'b0;
                    next_s.wdt_timeout          = 1'b1;
                end
            end
        end

        // Bus writes; expiry and power-down bits are read-only
        if (bus_req.wr) begin
            if (!bus_req.addr[7]) begin
                next_s.mem[bus_req.addr[6:0]] = bus_req.wdata;
            end else begin
                case (bus_req.addr)
                    `ADDR_ACCUM:     next_s.accumulator = bus_req.wdata;
                    `ADDR_STATUS:    next_s.zero = bus_req.wdata[`STAT_ZERO];
                    `ADDR_UPPER_PC:  next_s.upper_pc_latch = bus_req.wdata[4:0];
                    `ADDR_PC_LO:     next_s.pc[7:0] = bus_req.wdata;
                    `ADDR_PC_HI:     next_s.pc[12:8] = bus_req.wdata[4:0];
                    `ADDR_CONTROL:   next_s.wdt_enable =
                                         bus_req.wdata[`CTRL_WDT_EN];
                    default:         ;
                endcase
            end
        end

        // Bus reads answer in the next cycle; unmapped reads give zero
        if (bus_req.rd) begin
            if (!bus_req.addr[7]) begin
                next_s.bus_rdata = s.mem[bus_req.addr[6:0]];
            end else begin
                case (bus_req.addr)
                    `ADDR_ACCUM:     next_s.bus_rdata = s.accumulator;
                    `ADDR_STATUS:    next_s.bus_rdata = status_of(s);
                    `ADDR_UPPER_PC:  next_s.bus_rdata = {3'h0, s.upper_pc_latch};
                    `ADDR_PC_LO:     next_s.bus_rdata = s.pc[7:0];
                    `ADDR_PC_HI:     next_s.bus_rdata = {3'h0, s.pc[12:8]};
                    `ADDR_WDT_COUNT: next_s.bus_rdata = s.watchdog_counter;
                    `ADDR_WDT_PRE:   next_s.bus_rdata = s.wdt_prescaler;
                    `ADDR_CONTROL:   next_s.bus_rdata = {7'h00, s.wdt_enable};
                    `ADDR_STACK:     next_s.bus_rdata = stack_depth;
                    default:         next_s.bus_rdata = '0;
                endcase
            end
        end

        // Instruction sequencing
        case (s.state)
            ST_EXEC: begin
                if (instr_in.valid) begin
                    next_s.pc        = pc_plus_one;
                    next_s.nop_cycle = 1'b0;
                    if (dec_and_lit) begin
                        res                = s.accumulator & w[7:0];
                        next_s.accumulator = res;
                        next_s.zero        = is_zero(res);
                    end else if (dec_and_reg || dec_comp) begin
                        // Destination bit 7: one writes back, zero to W
                        res = dec_comp ? ~opnd
                                       : (s.accumulator & opnd);
                        if (w[7]) begin
                            next_s.mem[w[6:0]] = res;
                        end else begin
                            next_s.accumulator = res;
                        end
                        next_s.zero = is_zero(res);
                    end else if (dec_skip_clr || dec_skip_set) begin
                        // Flags left alone on either outcome
                        if (dec_skip_clr ? !tested_bit
                                         : tested_bit) begin
                            next_s.state          = ST_SECOND;
                            next_s.second_advance = 1'b1;
                            next_s.nop_cycle      = 1'b1;
                        end
                    end else if (dec_wdt_clr) begin
                        next_s.watchdog_counter     = '0;
                        next_s.wdt_prescaler        = '0;
                        next_s.watchdog_expiry_flag = 1'b1;
                        next_s.power_down_flag      = 1'b1;
                        next_s.wdt_timeout          = 1'b0;
                    end else if (dec_call) begin
                        push                  = 1'b1;
                        next_s.pc             = {s.upper_pc_latch[4:3],
                                                 w[10:0]};
                        next_s.state          = ST_SECOND;
                        next_s.second_advance = 1'b0;
                        next_s.nop_cycle      = 1'b1;
                    end
                end
            end
            ST_SECOND: begin
                // Word fetched here is dropped; a skip steps past it
                next_s.state     = ST_EXEC;
                next_s.nop_cycle = 1'b0;
                if (s.second_advance) begin
                    next_s.pc = pc_plus_one;
                end
            end
            default: begin
                next_s.state = ST_EXEC;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register; clock enable freezes everything
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= RESET_STATE;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------------
    return_stack #(
        .DEPTH     (STACK_DEPTH)
    ) u_return_stack (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .push      (push),
        .push_addr (pc_plus_one),
        .stack_top (stack_top),
        .depth     (stack_depth)
    );

    // Outputs straight from state flops
    assign bus_rdata        = s.bus_rdata;
    assign pc               = s.pc;
    assign nop_cycle        = s.nop_cycle;
    assign port_latch       = s.mem[`PORT_INDEX];
    assign watchdog_timeout = s.wdt_timeout;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_and_literal_acc: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_and_lit
        |=> s.accumulator == ($past(s.accumulator) & $past(w[7:0])))
        else $error("literal AND result wrong");

    // Write-back path; bus writes excluded so the accumulator must hold
    a_and_reg_dest: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_and_reg && w[7] && !bus_req.wr
        |=> (s.mem[$past(w[6:0])] == ($past(s.accumulator) & $past(opnd)))
        && $stable(s.accumulator))
        else $error("register AND result or target wrong");

    a_comp_reg_dest: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_comp && !w[7]
        |=> s.accumulator == ~$past(opnd))
        else $error("complement into accumulator wrong");

    a_zero_flag_match: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && (dec_and_lit || ((dec_and_reg || dec_comp) && !w[7]))
        |=> s.zero == (s.accumulator == 8'h00))
        else $error("zero flag disagrees with result");

    a_comp_port_pins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_comp && (w[6:0] == `PORT_INDEX)
        |=> ($past(w[7]) ? port_latch : s.accumulator) == ~$past(port_pins))
        else $error("port complement not taken from pins");

    a_skip_clear_nop: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_skip_clr && !tested_bit
        |=> nop_cycle && (pc == $past(pc_plus_one)))
        else $error("skip on clear missed");

    a_skip_set_nop: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_skip_set |=> nop_cycle == $past(tested_bit))
        else $error("skip on set wrong");

    a_test_flags_kept: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && (dec_skip_clr || dec_skip_set) && !bus_req.wr
        |=> $stable(s.zero) && $stable(s.power_down_flag))
        else $error("bit test altered a flag");

    a_wdt_clear_all: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_wdt_clr |=> (s.watchdog_counter == 8'h00)
        && (s.wdt_prescaler == 8'h00) && s.watchdog_expiry_flag
        && s.power_down_flag)
        else $error("watchdog clear incomplete");

    a_call_target_push: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_call |=> (pc == {$past(s.upper_pc_latch[4:3]),
        $past(w[10:0])}) && (stack_top == $past(pc_plus_one)))
        else $error("call target or return address wrong");

    a_call_two_cycles: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        fire && dec_call && !bus_req.wr
        |=> nop_cycle && $stable(s.zero) ##1 !nop_cycle)
        else $error("call did not take two cycles");

    // The dropped word must leave no trace; only a skip steps the pc
    a_second_drops_word: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.state == ST_SECOND) && clk_en && !bus_req.wr
        |=> !nop_cycle && $stable(s.accumulator)
        && (pc == ($past(s.second_advance) ? $past(pc_plus_one)
                                           : $past(pc))))
        else $error("second cycle did not act as no-operation");

    a_freeze_holds: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !clk_en |=> $stable(pc) && $stable(s.accumulator)
        && $stable(nop_cycle) && $stable(stack_top))
        else $error("state moved with clock enable low");

endmodule

`default_nettype wire

/* logic_skip_call_instr_exec_tb.sv */
// Self-checking bench for the instruction execution block.
// Assumes exec_defines.svh and exec_pkg are compiled first.
`default_nettype none

`include "exec_defines.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
    err_count++; $display("[ERR] %0t mismatch got %h exp %h", $time, \
    (got), (exp)); end end

module logic_skip_call_instr_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;

    logic         clk_sys   = 1'b0;
    logic         rst_n     = 1'b0;
    logic         clk_en    = 1'b1;
    instr_in_t    instr_in  = '0;
    logic [7:0]   port_pins = 8'h00;
    reg_bus_req_t bus_req   = '0;
    logic [7:0]   bus_rdata;
    logic [12:0]  pc;
    logic         nop_cycle;
    logic [7:0]   port_latch;
    logic [12:0]  stack_top;
    logic         watchdog_timeout;
    int           err_count    = 0;
    int           total_checks = 0;
    int           op;
    logic [7:0]   acc, v, r, x, st;
    logic [13:0]  w;
    logic [12:0]  p;
    logic [6:0]   f;
    logic [2:0]   b;
    logic [10:0]  k;
    logic [4:0]   lat;
    logic         d, zb, sk, set, hit;

    // ------------------------------------------------------------
    // Clock, design and expectation helpers
    // ------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;

    logic_skip_call_instr_exec uut (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .clk_en           (clk_en),
        .instr_in         (instr_in),
        .port_pins        (port_pins),
        .bus_req          (bus_req),
        .bus_rdata        (bus_rdata),
        .pc               (pc),
        .nop_cycle        (nop_cycle),
        .port_latch       (port_latch),
        .stack_top        (stack_top),
        .watchdog_timeout (watchdog_timeout)
    );

    // Expected result: op 2 is complement, others are AND
    function automatic logic [7:0] alu(input int op_sel,
                                       input logic [7:0] a,
                                       input logic [7:0] bv);
        return (op_sel == 2) ? ~bv : (a & bv);
    endfunction

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk_sys);
        bus_req <= '{a, dat, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    // Read data exist only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk_sys);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 dat = bus_rdata;
    endtask

    // During a forced no-op cycle an acc-clearing word is offered;
    // it must be dropped, which later acc checks reveal
    task automatic run(input logic [13:0] wd, input logic skp,
                       input logic [12:0] pc1, input logic [12:0] pc2);
        @(posedge clk_sys);
        instr_in <= '{1'b1, wd};
        @(posedge clk_sys);
        if (skp) begin
            instr_in <= '{1'b1, {`OP_AND_LIT, 8'h00}};
        end else begin
            instr_in <= '0;
        end
        #1 `CHK(nop_cycle, skp)
        `CHK(pc, pc1)
        if (skp) begin
            @(posedge clk_sys);
            instr_in <= '0;
            #1 `CHK(nop_cycle, 1'b0)
            `CHK(pc, pc2)
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h32a4));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus_rd(`ADDR_STATUS, st);
        `CHK(st[4:2], 3'b110)
        `CHK(pc, 13'h0000)
        bus_rd(8'hc0, x);
        `CHK(x, 8'h00)
        // Random AND and complement, zero results forced now and then
        for (int i = 0; i < 24; i++) begin
            acc = $urandom;
            v = $urandom;
            d = $urandom;
            f = (i == 1) ? 7'h00 : 7'($urandom_range(127, 6));
            op = i % 3;
            if (i % 4 == 0) v = ~acc;
            if (op == 0) d = 1'b0;
            r = alu(op, acc, v);
            w = (op == 0) ? {`OP_AND_LIT, v} :
                {(op == 1) ? `OP_AND_REG : `OP_COMP_REG, d, f};
            bus_wr(`ADDR_ACCUM, acc);
            bus_wr({1'b0, f}, v);
            p = pc;
            run(w, 1'b0, p + 13'd1, p);
            bus_rd(`ADDR_ACCUM, x);
            `CHK(x, d ? acc : r)
            bus_rd({1'b0, f}, x);
            `CHK(x, (op != 0 && d) ? r : v)
            bus_rd(`ADDR_STATUS, st);
            `CHK(st[`STAT_ZERO], r == 8'h00)
            `CHK(st[4:3], 2'b11)
        end
        $display("logic tests done");
        // Bit tests, every fourth on the port pins
        bus_wr(`ADDR_ACCUM, 8'hff);
        for (int i = 0; i < 16; i++) begin
            v = $urandom;
            b = (i < 8) ? 3'(i) : 3'($urandom);
            f = 7'($urandom_range(127, 6));
            zb = $urandom;
            set = i % 2;
            if (i % 4 == 3) begin
                f = `PORT_INDEX;
                port_pins <= v;
                v = ~v;
                bus_wr({1'b0, f}, v);
                v = ~v;
            end else begin
                bus_wr({1'b0, f}, v);
            end
            bus_wr(`ADDR_STATUS, {5'h00, zb, 2'h0});
            sk = set ? v[b] : ~v[b];
            w = {`OP_BIT_GROUP, set ? `OP_SKIP_SET : `OP_SKIP_CLR, b, f};
            p = pc;
            run(w, sk, p + 13'd1, p + 13'd2);
            bus_rd(`ADDR_STATUS, st);
            `CHK(st[4:2], {2'b11, zb})
        end
        bus_rd(`ADDR_ACCUM, x);
        `CHK(x, 8'hff)
        // Port operand comes from pins, not from the latch
        v = $urandom;
        port_pins <= v;
        bus_wr({1'b0, `PORT_INDEX}, ~v ^ 8'h5a);
        p = pc;
        run({`OP_COMP_REG, 1'b1, `PORT_INDEX}, 1'b0, p + 13'd1, p);
        `CHK(port_latch, ~v)
        $display("bit test done");
        // Calls, with both ends of the target range
        for (int i = 0; i < 6; i++) begin
            lat = $urandom;
            k = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($urandom);
            zb = $urandom;
            bus_wr(`ADDR_UPPER_PC, {3'h0, lat});
            bus_wr(`ADDR_STATUS, {5'h00, zb, 2'h0});
            p = pc;
            run({`OP_CALL, k}, 1'b1, {lat[4:3], k}, {lat[4:3], k});
            `CHK(stack_top, p + 13'd1)
            bus_rd(`ADDR_STATUS, st);
            `CHK(st[4:2], {2'b11, zb})
        end
        bus_rd(`ADDR_ACCUM, x);
        `CHK(x, 8'hff)
        // Clock enable low: a presented acc-clearing word must not run
        @(posedge clk_sys);
        clk_en   <= 1'b0;
        instr_in <= '{1'b1, {`OP_AND_LIT, 8'h00}};
        p = pc;
        repeat (3) @(posedge clk_sys);
        clk_en   <= 1'b1;
        instr_in <= '0;
        #1 `CHK(pc, p)
        bus_rd(`ADDR_ACCUM, x);
        `CHK(x, 8'hff)
        $display("call test done");
        // Let the watchdog expire, then clear it
        bus_wr(`ADDR_CONTROL, 8'h01);
        hit = 1'b0;
        for (int n = 0; n < 70000 && !hit; n++) begin
            @(posedge clk_sys);
            #1 hit = (watchdog_timeout === 1'b1);
        end
        `CHK(hit, 1'b1)
        bus_rd(`ADDR_STATUS, st);
        `CHK(st[`STAT_TO], 1'b0)
        p = pc;
        run(`INSTR_WDT_CLR, 1'b0, p + 13'd1, p);
        bus_rd(`ADDR_WDT_COUNT, x);
        `CHK(x, 8'h00)
        bus_rd(`ADDR_WDT_PRE, x);
        `CHK(x < 8'h10, 1'b1)
        bus_rd(`ADDR_STATUS, st);
        `CHK(st[4:3], 2'b11)
        $display("watchdog test done");
        test_done();
    end

    // Hang guard, well past the expected run length
    initial begin
        #(40 * 90000);
        err_count++;
        $display("[ERR] %0t run timed out", $time);
        test_done();
    end

endmodule

`default_nettype wire
